// >>> core/pmbus_regs_pkg.sv
// Constants, command codes and carrier types of the PMBus command register set.
// Assumes a serial front end that hands over decoded command transactions.
package pmbus_regs_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int PAGES = 8;
  localparam int PAGED_SLOTS = 10;
  localparam int FLAT_SLOTS = 11;
  localparam int NREG = PAGES * PAGED_SLOTS + FLAT_SLOTS;
  localparam logic [6:0] FLAT_BASE = 7'h50;
  localparam logic [6:0] WLOCK_IDX = 7'h5A;
  localparam logic [6:0] LAST_IDX = 7'h5A;
  localparam logic [7:0] PAGE_GLOBAL = 8'hFF;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_RUN_CONTROL = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
  localparam logic [7:0] CMD_STORE = 8'h15;
  localparam logic [7:0] CMD_RESTORE = 8'h16;
  localparam logic [7:0] CMD_FEATURE = 8'h19;
  localparam logic [7:0] CMD_OUT_FORMAT = 8'h20;
  localparam logic [7:0] CMD_GLOBAL_MASK = 8'hE4;
  // Paged output-voltage words, slot order
  localparam logic [PAGED_SLOTS-1:0][7:0] PAGED_CODES = {
    8'h5F, 8'h5E, 8'h44, 8'h43, 8'h42, 8'h40, 8'h26, 8'h25, 8'h24, 8'h21};
  localparam logic [3:0] SLOT_LIMIT_LO = 4'h4;
  localparam logic [3:0] SLOT_LIMIT_HI = 4'h7;
  // Unpaged input, temperature and lock words, slot order
  localparam logic [FLAT_SLOTS-1:0][7:0] FLAT_CODES = {
    8'h10, 8'h53, 8'h52, 8'h51, 8'h4F, 8'h59, 8'h58, 8'h57, 8'h55, 8'h36, 8'h35};

  // ****************************************
  // Fixed and reset values
  // ****************************************
  localparam logic [15:0] FEATURE_VALUE = 16'h00E0;
  localparam logic [2:0] OUT_FORMAT_TYPE = 3'h0;
  localparam logic [4:0] OUT_FORMAT_EXP = 5'h13;
  localparam logic [7:0] LOCK_NONE = 8'h00;
  localparam logic [7:0] LOCK_CONTROL = 8'h40;
  localparam logic [7:0] LOCK_ALL = 8'h80;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_SETUP = 2'b01,
    W_REQ = 2'b10,
    W_WAIT = 2'b11
  } walk_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic valid;
    logic ack;
    logic [15:0] rdata;
  } cmd_rsp_t;

  typedef struct packed {
    logic unpaged;
    logic paged;
    logic [2:0] page;
  } status_clr_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [6:0] addr;
  } nv_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } nv_rsp_t;

  typedef struct packed {
    logic hit;
    logic paged;
    logic [3:0] slot;
  } cmd_slot_t;

  typedef struct packed {
    walk_state_t state;
    logic busy;
    nv_req_t nv;
  } walk_st_t;

  typedef struct packed {
    logic [NREG-1:0][15:0] regs;
    logic [7:0] page;
    logic [7:0] gmask;
    logic [PAGES-1:0][7:0] run_ctl;
    logic alert_n;
    logic boot;
    cmd_rsp_t rsp;
    status_clr_t clr;
    logic [15:0] nv_wdata;
  } core_st_t;

  function automatic cmd_slot_t decode_cmd(input logic [7:0] code);
    cmd_slot_t d;
    d = '0;
    for (int i = 0; i < PAGED_SLOTS; i++) begin
      if (PAGED_CODES[i] == code) begin
        d = '{hit: 1'b1, paged: 1'b1, slot: 4'(i)};
      end
    end
    for (int i = 0; i < FLAT_SLOTS; i++) begin
      if (FLAT_CODES[i] == code) begin
        d = '{hit: 1'b1, paged: 1'b0, slot: 4'(i)};
      end
    end
    return d;
  endfunction

endpackage

// >>> core/nv_walker.sv
// Walks every stored register index for an EEPROM store or restore.
// Assumes an EEPROM engine that answers each request with one ack pulse.
`timescale 1ns/1ps
module nv_walker
  import pmbus_regs_pkg::*;
#(
  parameter logic [6:0] LAST = LAST_IDX
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic store,
  input wire logic ack,
  // Status and EEPROM request
  output logic busy,
  output nv_req_t nv
);

  walk_st_t st_reg;
  walk_st_t st_next;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.nv.req = 1'b0;
    case (st_reg.state)
      W_IDLE: begin
        if (start) begin
          st_next.busy = 1'b1;
          st_next.nv.write = store;
          st_next.nv.addr = 7'h00;
          st_next.state = W_SETUP;
        end
      end
      W_SETUP: begin
        st_next.nv.req = 1'b1;
        st_next.state = W_REQ;
      end
      W_REQ, W_WAIT: begin
        st_next.state = W_WAIT;
        if (ack) begin
          if (st_reg.nv.addr == LAST) begin
            st_next.busy = 1'b0;
            st_next.state = W_IDLE;
          end else begin
            st_next.nv.addr = st_reg.nv.addr + 7'h01;
            st_next.state = W_SETUP;
          end
        end
      end
      default: begin
        st_next.state = W_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{state: W_IDLE, busy: 1'b0, nv: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign nv = st_reg.nv;

endmodule

// >>> core/pmbus_cmd_regs.sv
// PMBus command register set: fault clear, write lock, EEPROM store/restore,
// feature byte, output format and linear threshold words.
// Assumes a serial front end giving one decoded transaction per CMD.valid pulse.
//
// Behaviour
// - Clear-faults zeroes unpaged and selected-page status
// - Clear-faults releases own alert drive
// - Clearing never restarts a latched-off channel
// - Persisting fault sets status and alert again
// - Clear-faults uses page register, ignores global page
// - Reads succeed regardless of write lock
// - Lock 0x80 allows only lock, page, store
// - Lock 0x40 also allows run, mask, clear
// - Lock zero allows all; other values reserved
// - Writes NACKed during store or restore
// - EEPROM restored after reset and on command
// - Store copies every stored register to EEPROM
// - Monitoring suspended during EEPROM transfers
// - Restore reloads every stored register from EEPROM
// - Feature byte read-only, 0xE0
// - Feature bus-speed bit reads one
// - Output format type fixed 000, linear
// - Output exponent fixed minus thirteen
// - Output voltage words are 16-bit unsigned mantissas
// - Odd current-sense channels reject output limit words
// - Input words: 5-bit exponent, 11-bit mantissa
// - Temperature words use same linear format
`timescale 1ns/1ps
module pmbus_cmd_regs
  import pmbus_regs_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Command transactions
  input wire cmd_req_t CMD,
  output cmd_rsp_t RSP,
  // Status and alert
  input wire logic FAULT_EVENT,
  input wire logic [PAGES/2-1:0] ISENSE_ODD,
  output status_clr_t STATUS_CLR,
  output logic HOST_ALERT_N,
  output logic MONITOR_HOLD,
  // EEPROM engine
  output nv_req_t NV_OUT,
  output logic [15:0] NV_WDATA,
  input wire nv_rsp_t NV_IN
);

  core_st_t st_reg;
  core_st_t st_next;
  cmd_slot_t dec;
  logic [2:0] pg;
  logic global_pg;
  logic busy;
  logic wr_ok;
  logic walk_start;
  logic walk_store;
  nv_req_t walk_nv;
  logic [7:0] lock;
  logic [6:0] idx;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic unsupported(input logic [3:0] slot, input logic [2:0] p,
                                       input logic [PAGES/2-1:0] isense);
    return (slot >= SLOT_LIMIT_LO) && (slot <= SLOT_LIMIT_HI) && p[0] && isense[p[2:1]];
  endfunction

  function automatic logic lock_permits(input logic [7:0] lv, input logic [7:0] code);
    logic base;
    base = (code == CMD_WRITE_LOCK) || (code == CMD_PAGE) || (code == CMD_STORE);
    if (lv == LOCK_NONE) begin
      return 1'b1;
    end else if (lv == LOCK_CONTROL) begin
      return base || (code == CMD_RUN_CONTROL) || (code == CMD_GLOBAL_MASK) ||
             (code == CMD_CLEAR_FAULTS);
    end else begin
      return base;
    end
  endfunction

  // ****************************************
  // EEPROM walker
  // ****************************************
  nv_walker #(
    .LAST(LAST_IDX)
  ) u_walker (
    .clk(CORE_CLK),
    .rst(RST),
    .start(walk_start),
    .store(walk_store),
    .ack(NV_IN.ack),
    .busy(busy),
    .nv(walk_nv)
  );

  // ****************************************
  // Command handling
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.rsp = '0;
    st_next.clr = '0;
    st_next.boot = 1'b0;
    dec = decode_cmd(CMD.code);
    pg = st_reg.page[2:0];
    global_pg = (st_reg.page == PAGE_GLOBAL);
    lock = st_reg.regs[WLOCK_IDX][7:0];
    idx = dec.paged ? 7'({dec.slot, pg}) : 7'(FLAT_BASE + 7'(dec.slot));
    walk_start = st_reg.boot;
    walk_store = 1'b0;
    wr_ok = CMD.valid && CMD.write && !busy && !st_reg.boot && lock_permits(lock, CMD.code);
    if (CMD.valid && !CMD.write) begin
      st_next.rsp.valid = 1'b1;
      st_next.rsp.ack = 1'b1;
      case (CMD.code)
        CMD_PAGE: st_next.rsp.rdata = {8'h00, st_reg.page};
        CMD_RUN_CONTROL: st_next.rsp.rdata = {8'h00, st_reg.run_ctl[pg]};
        CMD_GLOBAL_MASK: st_next.rsp.rdata = {8'h00, st_reg.gmask};
        CMD_FEATURE: st_next.rsp.rdata = FEATURE_VALUE;
        CMD_OUT_FORMAT: st_next.rsp.rdata = {8'h00, OUT_FORMAT_TYPE, OUT_FORMAT_EXP};
        default: begin
          if (dec.hit && !(dec.paged && unsupported(dec.slot, pg, ISENSE_ODD))) begin
            st_next.rsp.rdata = st_reg.regs[idx];
          end else begin
            st_next.rsp.ack = 1'b0;
          end
        end
      endcase
    end else if (CMD.valid) begin
      st_next.rsp.valid = 1'b1;
      st_next.rsp.ack = wr_ok;
      if (wr_ok) begin
        case (CMD.code)
          CMD_PAGE: begin
            if (CMD.wdata[7:0] < 8'(PAGES) || CMD.wdata[7:0] == PAGE_GLOBAL) begin
              st_next.page = CMD.wdata[7:0];
            end else begin
              st_next.rsp.ack = 1'b0;
            end
          end
          CMD_RUN_CONTROL: begin
            for (int p = 0; p < PAGES; p++) begin
              if (global_pg ? st_reg.gmask[p] : (pg == 3'(p))) begin
                st_next.run_ctl[p] = CMD.wdata[7:0];
              end
            end
          end
          CMD_GLOBAL_MASK: st_next.gmask = CMD.wdata[7:0];
          CMD_CLEAR_FAULTS: begin
            st_next.clr.unpaged = 1'b1;
            st_next.clr.paged = !global_pg;
            st_next.clr.page = pg;
            st_next.alert_n = 1'b1;
            // Only status and alert are touched; latched-off channels stay off
          end
          CMD_STORE, CMD_RESTORE: begin
            walk_start = 1'b1;
            walk_store = (CMD.code == CMD_STORE);
          end
          CMD_WRITE_LOCK: begin
            if (CMD.wdata[7:0] == LOCK_NONE || CMD.wdata[7:0] == LOCK_CONTROL ||
                CMD.wdata[7:0] == LOCK_ALL) begin
              st_next.regs[WLOCK_IDX] = {8'h00, CMD.wdata[7:0]};
            end else begin
              st_next.rsp.ack = 1'b0;
            end
          end
          default: begin
            if (!dec.hit) begin
              st_next.rsp.ack = 1'b0;
            end else if (dec.paged && global_pg) begin
              for (int p = 0; p < PAGES; p++) begin
                if (st_reg.gmask[p] && !unsupported(dec.slot, 3'(p), ISENSE_ODD)) begin
                  st_next.regs[7'({dec.slot, 3'(p)})] = CMD.wdata;
                end
              end
            end else if (dec.paged && unsupported(dec.slot, pg, ISENSE_ODD)) begin
              st_next.rsp.ack = 1'b0;
            end else begin
              st_next.regs[idx] = CMD.wdata;
            end
          end
        endcase
      end
      // A refused write stores nothing
    end
    if (busy && !walk_nv.write && NV_IN.ack) begin
      st_next.regs[walk_nv.addr] = NV_IN.rdata;
    end
    st_next.nv_wdata = st_reg.regs[walk_nv.addr];
    if (FAULT_EVENT) begin
      st_next.alert_n = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '{regs: {NREG{REG_RESET}}, page: PAGE_RESET, gmask: MASK_RESET,
                  run_ctl: '0, alert_n: 1'b1, boot: 1'b1, rsp: '0, clr: '0,
                  nv_wdata: REG_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RSP = st_reg.rsp;
  assign STATUS_CLR = st_reg.clr;
  assign HOST_ALERT_N = st_reg.alert_n;
  assign MONITOR_HOLD = busy;
  assign NV_OUT = walk_nv;
  assign NV_WDATA = st_reg.nv_wdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  sequence s_clear_taken;
    wr_ok && CMD.code == CMD_CLEAR_FAULTS;
  endsequence

  sequence s_xfer_taken;
    wr_ok && (CMD.code == CMD_STORE || CMD.code == CMD_RESTORE);
  endsequence

  property p_clear_alert;
    s_clear_taken and !FAULT_EVENT |=> HOST_ALERT_N;
  endproperty
  a_clear_alert: assert property (p_clear_alert) else $error("alert not released by clear");

  property p_fault_alert;
    FAULT_EVENT |=> !HOST_ALERT_N;
  endproperty
  a_fault_alert: assert property (p_fault_alert) else $error("fault did not assert alert");

  property p_clear_page;
    s_clear_taken and (st_reg.page != PAGE_GLOBAL) |=>
      STATUS_CLR.unpaged && STATUS_CLR.paged && STATUS_CLR.page == $past(st_reg.page[2:0]) ##1
      !STATUS_CLR.unpaged;
  endproperty
  a_clear_page: assert property (p_clear_page) else $error("paged clear wrong");

  property p_clear_global;
    s_clear_taken and (st_reg.page == PAGE_GLOBAL) |=> STATUS_CLR.unpaged && !STATUS_CLR.paged;
  endproperty
  a_clear_global: assert property (p_clear_global) else $error("global page not ignored");

  property p_busy_nack;
    CMD.valid && CMD.write && busy |=> RSP.valid && !RSP.ack;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("write acked during transfer");

  property p_lock_all;
    CMD.valid && CMD.write && lock == LOCK_ALL && CMD.code == CMD_CLEAR_FAULTS |=>
      !RSP.ack && $stable(HOST_ALERT_N) || $past(FAULT_EVENT);
  endproperty
  a_lock_all: assert property (p_lock_all) else $error("locked clear accepted");

  property p_lock_control;
    CMD.valid && CMD.write && !busy && !st_reg.boot && lock == LOCK_CONTROL &&
      CMD.code == CMD_GLOBAL_MASK |=> RSP.ack;
  endproperty
  a_lock_control: assert property (p_lock_control) else $error("permitted write refused");

  property p_blocked_stable;
    CMD.valid && CMD.write && !busy && lock == LOCK_ALL && CMD.code == PAGED_CODES[0] |=>
      $stable(st_reg.regs);
  endproperty
  a_blocked_stable: assert property (p_blocked_stable) else $error("blocked write changed data");

  property p_feature_read;
    CMD.valid && !CMD.write && CMD.code == CMD_FEATURE |=> RSP.ack && RSP.rdata == 16'h00E0;
  endproperty
  a_feature_read: assert property (p_feature_read) else $error("feature byte wrong");

  property p_format_read;
    CMD.valid && !CMD.write && CMD.code == CMD_OUT_FORMAT |=> RSP.ack && RSP.rdata == 16'h0013;
  endproperty
  a_format_read: assert property (p_format_read) else $error("output format wrong");

  property p_xfer_hold;
    s_xfer_taken |=> MONITOR_HOLD ##1 NV_OUT.req;
  endproperty
  a_xfer_hold: assert property (p_xfer_hold) else $error("transfer did not start");

  property p_restore_load;
    busy && !NV_OUT.write && NV_IN.ack |=> st_reg.regs[$past(NV_OUT.addr)] == $past(NV_IN.rdata);
  endproperty
  a_restore_load: assert property (p_restore_load) else $error("restore word not loaded");

  property p_read_ack;
    CMD.valid && !CMD.write && dec.hit && !dec.paged |=> RSP.valid && RSP.ack;
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("supported read refused");

  property p_feature_nowrite;
    CMD.valid && CMD.write && CMD.code == CMD_FEATURE |=> RSP.valid && !RSP.ack;
  endproperty
  a_feature_nowrite: assert property (p_feature_nowrite) else $error("feature byte written");

  property p_format_nowrite;
    CMD.valid && CMD.write && CMD.code == CMD_OUT_FORMAT |=> RSP.valid && !RSP.ack;
  endproperty
  a_format_nowrite: assert property (p_format_nowrite) else $error("output format written");

  property p_unsup_nack;
    CMD.valid && dec.paged && !global_pg && unsupported(dec.slot, pg, ISENSE_ODD) |=> RSP.valid && !RSP.ack;
  endproperty
  a_unsup_nack: assert property (p_unsup_nack) else $error("unsupported limit accepted");

  property p_lock_none;
    CMD.valid && CMD.write && !busy && !st_reg.boot && lock == LOCK_NONE && dec.hit && !dec.paged &&
      CMD.code != CMD_WRITE_LOCK |=> RSP.ack;
  endproperty
  a_lock_none: assert property (p_lock_none) else $error("open lock refused write");

  property p_store_dir;
    wr_ok && CMD.code == CMD_STORE |=> ##1 NV_OUT.req && NV_OUT.write && NV_OUT.addr == 7'h00;
  endproperty
  a_store_dir: assert property (p_store_dir) else $error("store walk wrong");

  property p_restore_dir;
    wr_ok && CMD.code == CMD_RESTORE |=> ##1 NV_OUT.req && !NV_OUT.write && NV_OUT.addr == 7'h00;
  endproperty
  a_restore_dir: assert property (p_restore_dir) else $error("restore walk wrong");

  property p_req_in_hold;
    NV_OUT.req |-> MONITOR_HOLD;
  endproperty
  a_req_in_hold: assert property (p_req_in_hold) else $error("request outside transfer");

endmodule

// >>> bench/nv_store_model.sv
// EEPROM engine partner: answers each request with one ack pulse.
// Assumes single-cycle request pulses, one outstanding at a time.
`timescale 1ns/1ps
module nv_store_model
  import pmbus_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request side
  input wire nv_req_t nv,
  input wire logic [15:0] wdata,
  // Answer side
  output nv_rsp_t rsp
);
  logic [15:0] mem [0:90];
  logic pend;
  logic [1:0] wait_cnt;
  logic [6:0] addr_hold;

  // ****************************************
  // Stored image, lock byte left open
  // ****************************************
  initial begin
    for (int i = 0; i < 91; i++) begin
      mem[i] = (i == 90) ? 16'h0000 : 16'(i * 16'h0123 + 16'h0400);
    end
  end

  // Delay of 0..3 cycles from the address, data toggles when idle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      wait_cnt <= 2'h0;
      addr_hold <= 7'h00;
      rsp <= '{ack: 1'b0, rdata: 16'hFFFF};
    end else begin
      rsp.ack <= 1'b0;
      rsp.rdata <= ~rsp.rdata;
      if (nv.req) begin
        pend <= 1'b1;
        wait_cnt <= nv.addr[1:0];
        addr_hold <= nv.addr;
      end else if (pend) begin
        if (wait_cnt == 2'h0) begin
          pend <= 1'b0;
          rsp.ack <= 1'b1;
          if (nv.write) begin
            mem[addr_hold] <= wdata;
          end else begin
            rsp.rdata <= mem[addr_hold];
          end
        end else begin
          wait_cnt <= wait_cnt - 2'h1;
        end
      end
    end
  end
endmodule

// >>> bench/tb_pmbus_cmd_regs.sv
// Self-checking testbench of the PMBus command register set.
// Assumes the EEPROM partner model nv_store_model.
`timescale 1ns/1ps
module tb_pmbus_cmd_regs
  import pmbus_regs_pkg::*;
;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  cmd_req_t CMD = '0;
  cmd_rsp_t RSP;
  cmd_rsp_t rsp_seen;
  logic FAULT_EVENT = 1'b0;
  logic [3:0] ISENSE_ODD = 4'h0;
  status_clr_t STATUS_CLR;
  status_clr_t clr_seen;
  logic HOST_ALERT_N;
  logic alert_seen;
  logic MONITOR_HOLD;
  nv_req_t NV_OUT;
  logic [15:0] NV_WDATA;
  nv_rsp_t NV_IN;
  logic [15:0] shadow [0:90];
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 32'hda0b;
  int pg = 0;

  always #25 CORE_CLK = ~CORE_CLK;

  pmbus_cmd_regs uut (.CORE_CLK(CORE_CLK), .RST(RST), .CMD(CMD), .RSP(RSP), .FAULT_EVENT(FAULT_EVENT),
    .ISENSE_ODD(ISENSE_ODD), .STATUS_CLR(STATUS_CLR), .HOST_ALERT_N(HOST_ALERT_N),
    .MONITOR_HOLD(MONITOR_HOLD), .NV_OUT(NV_OUT), .NV_WDATA(NV_WDATA), .NV_IN(NV_IN));
  nv_store_model ee (.clk(CORE_CLK), .rst(RST), .nv(NV_OUT), .wdata(NV_WDATA), .rsp(NV_IN));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic int ridx(input logic [7:0] c, input int p);
    ridx = -1;
    for (int i = 0; i < PAGED_SLOTS; i++) if (PAGED_CODES[i] == c) ridx = i * 8 + p;
    for (int i = 0; i < FLAT_SLOTS; i++) if (FLAT_CODES[i] == c) ridx = 80 + i;
  endfunction

  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge CORE_CLK);
    CMD <= '{valid: 1'b1, write: w, code: c, wdata: d};
    @(posedge CORE_CLK);
    CMD.valid <= 1'b0;
    #1;
    rsp_seen = RSP;
    clr_seen = STATUS_CLR;
    alert_seen = HOST_ALERT_N;
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
    cmd(1'b1, c, d);
    chk("write answer", 16'({1'b1, e}), 16'({rsp_seen.valid, rsp_seen.ack}));
    if (e && c == CMD_PAGE) pg = int'(d[2:0]);
    if (e && ridx(c, pg) >= 0) shadow[ridx(c, pg)] = d;
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    cmd(1'b0, c, 16'h0000);
    chk("read answer", 16'h0003, 16'({rsp_seen.valid, rsp_seen.ack}));
    chk("read data", exp, rsp_seen.rdata);
  endtask

  task automatic check_all;
    for (int p = 0; p < 8; p++) begin
      wr(CMD_PAGE, 16'(p), 1'b1);
      for (int s = 0; s < PAGED_SLOTS; s++) rd(PAGED_CODES[s], shadow[s * 8 + p]);
    end
    for (int s = 0; s < FLAT_SLOTS; s++) rd(FLAT_CODES[s], shadow[80 + s]);
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 3000 && MONITOR_HOLD !== 1'b0; i++) @(posedge CORE_CLK);
    chk("transfer done", 16'h0000, 16'(MONITOR_HOLD));
    #1;
    for (int i = 0; i < 91; i++) shadow[i] = ee.mem[i];
  endtask

  task automatic pulse_fault;
    @(posedge CORE_CLK);
    FAULT_EVENT <= 1'b1;
    @(posedge CORE_CLK);
    FAULT_EVENT <= 1'b0;
    @(posedge CORE_CLK);
    #1;
  endtask

  // ****************************************
  // Watchdog and main sequence
  // ****************************************
  initial begin
    repeat (40000) @(posedge CORE_CLK);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen hang");
    close_out();
  end

  initial begin
    logic [7:0] lvl [3];
    logic [5:0] allow [3];
    logic [5:0][7:0] codes;
    logic [15:0] d;
    int s;
    lvl = '{LOCK_ALL, LOCK_CONTROL, LOCK_NONE};
    allow = '{6'h20, 6'h3C, 6'h3F};
    codes = {CMD_PAGE, CMD_RUN_CONTROL, CMD_CLEAR_FAULTS, CMD_GLOBAL_MASK, 8'h21, 8'h35};
    repeat (20) @(posedge CORE_CLK);
    RST <= 1'b0;
    wr(8'h21, 16'h1234, 1'b0);
    chk("hold at boot", 16'h0001, 16'(MONITOR_HOLD));
    cmd(1'b0, CMD_FEATURE, 16'h0000);
    chk("boot read", 16'h0003, 16'({rsp_seen.valid, rsp_seen.ack}));
    wait_idle();
    check_all();
    rd(CMD_FEATURE, 16'h00E0);
    wr(CMD_FEATURE, 16'h0000, 1'b0);
    rd(CMD_OUT_FORMAT, 16'h0013);
    wr(CMD_OUT_FORMAT, 16'h0000, 1'b0);
    for (int i = 0; i < 40; i++) begin
      wr(CMD_PAGE, 16'($unsigned($random(seed)) % 8), 1'b1);
      s = $unsigned($random(seed)) % 20;
      d = 16'($random(seed));
      wr((s < 10) ? PAGED_CODES[s] : FLAT_CODES[s - 10], d, 1'b1);
    end
    wr(8'h21, 16'hFFFF, 1'b1);
    check_all();
    ISENSE_ODD <= 4'h1;
    wr(CMD_PAGE, 16'h0001, 1'b1);
    wr(8'h40, 16'h5555, 1'b0);
    wr(8'h21, 16'h5555, 1'b1);
    wr(CMD_PAGE, 16'h0003, 1'b1);
    wr(8'h40, 16'h6666, 1'b1);
    ISENSE_ODD <= 4'h0;
    wr(CMD_RUN_CONTROL, 16'h0080, 1'b1);
    pulse_fault();
    chk("alert raised", 16'h0000, 16'(HOST_ALERT_N));
    wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
    chk("clear pulse", 16'h001B, 16'(clr_seen));
    chk("alert released", 16'h0001, 16'(alert_seen));
    rd(CMD_RUN_CONTROL, 16'h0080);
    pulse_fault();
    chk("alert again", 16'h0000, 16'(HOST_ALERT_N));
    wr(CMD_PAGE, 16'h00FF, 1'b1);
    wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
    chk("global clear", 16'h0002, 16'(clr_seen[4:3]));
    wr(CMD_PAGE, 16'h0000, 1'b1);
    for (int l = 0; l < 3; l++) begin
      wr(CMD_WRITE_LOCK, 16'(lvl[l]), 1'b1);
      for (int k = 5; k >= 0; k--) begin
        d = (k == 5) ? 16'h0000 : (k == 4) ? 16'h0080 : (k == 2) ? 16'h00FF : 16'($random(seed));
        wr(codes[k], d, allow[l][k]);
      end
      rd(8'h21, shadow[ridx(8'h21, 0)]);
    end
    wr(CMD_WRITE_LOCK, 16'h0020, 1'b0);
    rd(CMD_WRITE_LOCK, 16'h0000);
    wr(CMD_WRITE_LOCK, 16'(LOCK_ALL), 1'b1);
    wr(CMD_RESTORE, 16'h0000, 1'b0);
    wr(CMD_STORE, 16'h0000, 1'b1);
    chk("hold in store", 16'h0001, 16'(MONITOR_HOLD));
    wr(CMD_WRITE_LOCK, 16'(LOCK_NONE), 1'b0);
    rd(CMD_FEATURE, 16'h00E0);
    for (int i = 0; i < 91; i++) d = shadow[i];
    for (int i = 0; i < 3000 && MONITOR_HOLD !== 1'b0; i++) @(posedge CORE_CLK);
    #1;
    for (int i = 0; i < 91; i++) chk("stored word", shadow[i], ee.mem[i]);
    wr(CMD_WRITE_LOCK, 16'(LOCK_NONE), 1'b1);
    wr(8'h21, 16'hBEEF, 1'b1);
    wr(8'h36, 16'h0BAD, 1'b1);
    wr(CMD_RESTORE, 16'h0000, 1'b1);
    wait_idle();
    check_all();
    close_out();
  end
endmodule
